// >>> design/gp_timer_pkg.sv
// package for the general timer: register map, field positions, reset values,
// configuration codes and the real-time-clock divide ratio.
// assumes a 32-bit classic wishbone slave with word-aligned byte addresses.
package gp_timer_pkg;

  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] CFG_OFS     = 8'h00;
  localparam logic [7:0] AMODE_OFS   = 8'h04;
  localparam logic [7:0] BMODE_OFS   = 8'h08;
  localparam logic [7:0] CTL_OFS     = 8'h0c;
  localparam logic [7:0] IMR_OFS     = 8'h18;
  localparam logic [7:0] RIS_OFS     = 8'h1c;
  localparam logic [7:0] MIS_OFS     = 8'h20;
  localparam logic [7:0] ICR_OFS     = 8'h24;
  localparam logic [7:0] ALOAD_OFS   = 8'h28;
  localparam logic [7:0] BLOAD_OFS   = 8'h2c;
  localparam logic [7:0] AMATCH_OFS  = 8'h30;
  localparam logic [7:0] BMATCH_OFS  = 8'h34;
  localparam logic [7:0] APRE_OFS    = 8'h38;
  localparam logic [7:0] BPRE_OFS    = 8'h3c;
  localparam logic [7:0] ACOUNT_OFS  = 8'h48;
  localparam logic [7:0] BCOUNT_OFS  = 8'h4c;
  localparam int         ADDR_W      = 8;

  // ------------------------------------------------------------
  // configuration codes and mode field values
  // ------------------------------------------------------------
  localparam logic [2:0] CFG_32_TIMER = 3'h0;
  localparam logic [2:0] CFG_32_RTC   = 3'h1;
  localparam logic [2:0] CFG_16       = 3'h4;
  localparam logic [1:0] MODE_ONESHOT = 2'h1;
  localparam logic [1:0] MODE_PERIOD  = 2'h2;

  // ------------------------------------------------------------
  // control bits
  // ------------------------------------------------------------
  localparam int CTL_AEN    = 0;
  localparam int CTL_ASTALL = 1;
  localparam int CTL_CLOCK_STALL_OVERRIDE_ENABLE  = 4;
  localparam int CTL_AOTE   = 5;
  localparam int CTL_BEN    = 8;
  localparam int CTL_BSTALL = 9;
  localparam int CTL_BOTE   = 13;
  localparam int CTL_W      = 14;

  // ------------------------------------------------------------
  // interrupt status bits
  // ------------------------------------------------------------
  localparam int INT_ATO = 0;
  localparam int INT_RTC = 3;
  localparam int INT_BTO = 8;
  localparam int INT_W   = 9;

  // ------------------------------------------------------------
  // reset values, clock start and wrap values
  // ------------------------------------------------------------
  localparam logic [15:0] HALF_RST    = 16'hffff;
  localparam logic [7:0]  PRE_RST     = 8'h00;
  localparam logic [31:0] RTC_FIRST   = 32'h0000_0001;
  localparam logic [31:0] RTC_WRAP    = 32'h0000_0000;

  // ------------------------------------------------------------
  // real-time clock: 32.768 kHz in, 1 Hz out
  // ------------------------------------------------------------
  localparam int RTC_IN_HZ  = 32768;
  localparam int RTC_OUT_HZ = 1;
  localparam int RTC_DIV    = RTC_IN_HZ / RTC_OUT_HZ;

endpackage

// >>> design/half_counter.sv
// one 16-bit counter half in 16-bit one-shot/periodic mode with its 8-bit
// prescaler.  assumes the parent gives a run level and a load pulse.
`timescale 1ns/1ns
module half_counter
  import gp_timer_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        run,
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  input  wire logic [7:0]  pre_val,
  output logic      [15:0] count_reg,
  output logic             zero_reg
);

  logic [7:0] pre_cnt_reg;

  // ------------------------------------------------------------
  // prescaled down-counter
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      count_reg   <= HALF_RST;
      pre_cnt_reg <= PRE_RST;
      zero_reg    <= 1'b0;
    end else begin
      zero_reg <= 1'b0;
      if (load) begin
        count_reg   <= load_val;
        pre_cnt_reg <= pre_val;
      end else if (run) begin
        if (pre_cnt_reg != 8'h00) begin
          pre_cnt_reg <= pre_cnt_reg - 8'h01;
        end else if (count_reg == 16'h0000) begin
          count_reg   <= load_val;
          pre_cnt_reg <= pre_val;
        end else begin
          pre_cnt_reg <= pre_val;
          count_reg   <= count_reg - 16'h0001;
          zero_reg    <= (count_reg == 16'h0001);
        end
      end
    end
  end

endmodule

// >>> design/gp_timer.sv
// general timer with two 16-bit halves, combinable into one 32-bit timer or
// a 32-bit real-time clock.  wishbone classic slave, one clock, no interrupt
// output; the capture pin carries the 32.768 kHz reference in clock mode.
//
// Overview of operation
// - two 16-bit halves, or joined 32-bit
// - prescaler only in one-shot or periodic
// - 32-bit config runs only joined timer
// - reset leaves block idle, controls cleared
// - counters and loads reset to all ones
// - prescale registers reset to zero
// - config 0 timer, 1 clock, halves joined
// - 32-bit load write splits into halves
// - 32-bit count read joins both halves
// - in 32-bit only first half mode field matters
// - enable counts down, reloads after zero
// - one-shot stops and clears enable
// - zero sets raw flag, masked if unmasked
// - zero pulses trigger when enabled
// - load write while running takes effect
// - stall input freezes count when enabled
// - clock mode counts up, starts at one
// - capture clock divided to one hertz
// - match wraps clock count to zero
// - match sets raw flag, masked if unmasked
// - clock override bit ignores stall
`timescale 1ns/1ns
module gp_timer
  import gp_timer_pkg::*;
#(
  parameter int RTC_DIVIDE = RTC_DIV
)(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        capture_pin_0,
  input  wire logic        stall_in,
  output logic             first_trigger_reg,
  output logic             second_trigger_reg
);

  initial begin
    if (RTC_DIVIDE < 2 || RTC_DIVIDE > 65536) begin
      $error("RTC_DIVIDE out of range");
    end
  end

  logic [2:0]        timer_config_reg;
  logic [1:0]        first_half_mode_reg;
  logic [1:0]        second_half_mode_reg;
  logic [CTL_W-1:0]  timer_control_reg;
  logic [INT_W-1:0]  int_mask_reg;
  logic [INT_W-1:0]  raw_int_status_reg;
  logic [15:0]       first_half_load_reg;
  logic [15:0]       second_half_load_reg;
  logic [15:0]       first_half_match_reg;
  logic [15:0]       second_half_match_reg;
  logic [7:0]        first_half_prescale_reg;
  logic [7:0]        second_half_prescale_reg;
  logic [31:0]       wide_count_reg;
  logic              rtc_started_reg;
  logic [15:0]       div_reg;
  logic [2:0]        cap_sync_reg;
  logic [15:0]       a_count;
  logic [15:0]       b_count;
  logic              a_zero;
  logic              b_zero;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic        bus_req;
  logic        wr;
  logic [31:0] wdat;
  logic        is32;
  logic        is_rtc;
  logic        is_tmr32;
  logic        load_a_wr;
  logic        load_b_wr;
  logic        icr_wr;
  logic        match_a_wr;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  function automatic logic wr_at(input logic [7:0] ofs);
    return wr && (wb_adr_i == ofs);
  endfunction

  assign bus_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr         = bus_req && wb_we_i;
  assign is_tmr32   = (timer_config_reg == CFG_32_TIMER);
  assign is_rtc     = (timer_config_reg == CFG_32_RTC);
  assign is32       = is_tmr32 || is_rtc;
  assign load_a_wr  = wr_at(ALOAD_OFS);
  assign load_b_wr  = wr_at(BLOAD_OFS) && !is32;
  assign icr_wr     = wr_at(ICR_OFS);
  assign match_a_wr = wr_at(AMATCH_OFS);
  assign wdat       = merge(32'h0000_0000, wb_dat_i, wb_sel_i);

  // ------------------------------------------------------------
  // configuration and control registers
  // ------------------------------------------------------------
  logic a_en;
  logic a_oneshot;
  logic a_stalled;
  logic b_stalled;
  logic tmr32_run;
  logic tmr32_zero;
  logic rtc_tick;
  logic rtc_match;

  assign a_en      = timer_control_reg[CTL_AEN];
  assign a_oneshot = (first_half_mode_reg == MODE_ONESHOT);
  assign a_stalled = timer_control_reg[CTL_ASTALL] && stall_in;
  assign b_stalled = timer_control_reg[CTL_BSTALL] && stall_in;
  assign tmr32_run = is_tmr32 && a_en && !a_stalled;
  assign tmr32_zero = tmr32_run && !load_a_wr && (wide_count_reg == 32'h0000_0000);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      timer_config_reg     <= CFG_32_TIMER;
      first_half_mode_reg  <= 2'h0;
      second_half_mode_reg <= 2'h0;
      int_mask_reg         <= '0;
    end else begin
      if (wr_at(CFG_OFS)) timer_config_reg <= wdat[2:0];
      if (wr_at(AMODE_OFS)) first_half_mode_reg <= wdat[1:0];
      if (wr_at(BMODE_OFS)) second_half_mode_reg <= wdat[1:0];
      if (wr_at(IMR_OFS)) int_mask_reg <= wdat[INT_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      timer_control_reg <= '0;
    end else if (wr_at(CTL_OFS)) begin
      timer_control_reg <= wdat[CTL_W-1:0];
    end else begin
      if (tmr32_zero && a_oneshot) timer_control_reg[CTL_AEN] <= 1'b0;
      if (!is32 && a_zero && first_half_mode_reg == MODE_ONESHOT) timer_control_reg[CTL_AEN] <= 1'b0;
      if (!is32 && b_zero && second_half_mode_reg == MODE_ONESHOT) timer_control_reg[CTL_BEN] <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // load, match and prescale registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      first_half_load_reg      <= HALF_RST;
      second_half_load_reg     <= HALF_RST;
      first_half_match_reg     <= HALF_RST;
      second_half_match_reg    <= HALF_RST;
      first_half_prescale_reg  <= PRE_RST;
      second_half_prescale_reg <= PRE_RST;
    end else begin
      if (load_a_wr) begin
        first_half_load_reg <= wdat[15:0];
        if (is32) second_half_load_reg <= wdat[31:16];
      end
      if (load_b_wr) second_half_load_reg <= wdat[15:0];
      if (match_a_wr) begin
        first_half_match_reg <= wdat[15:0];
        if (is32) second_half_match_reg <= wdat[31:16];
      end
      if (wr_at(BMATCH_OFS) && !is32) second_half_match_reg <= wdat[15:0];
      if (wr_at(APRE_OFS)) first_half_prescale_reg <= wdat[7:0];
      if (wr_at(BPRE_OFS)) second_half_prescale_reg <= wdat[7:0];
    end
  end

  // ------------------------------------------------------------
  // 16-bit halves, prescaler only in one-shot/periodic
  // ------------------------------------------------------------
  logic a_tmode;
  logic b_tmode;
  assign a_tmode = (first_half_mode_reg == MODE_ONESHOT) || (first_half_mode_reg == MODE_PERIOD);
  assign b_tmode = (second_half_mode_reg == MODE_ONESHOT) || (second_half_mode_reg == MODE_PERIOD);

  half_counter u_half_a (
    .clk       (clk),
    .nrst      (nrst),
    .run       (!is32 && a_tmode && a_en && !a_stalled),
    .load      (load_a_wr && !is32),
    .load_val  (load_a_wr ? wdat[15:0] : first_half_load_reg),
    .pre_val   (a_tmode ? first_half_prescale_reg : 8'h00),
    .count_reg (a_count),
    .zero_reg  (a_zero)
  );

  half_counter u_half_b (
    .clk       (clk),
    .nrst      (nrst),
    .run       (!is32 && b_tmode && timer_control_reg[CTL_BEN] && !b_stalled),
    .load      (load_b_wr),
    .load_val  (load_b_wr ? wdat[15:0] : second_half_load_reg),
    .pre_val   (b_tmode ? second_half_prescale_reg : 8'h00),
    .count_reg (b_count),
    .zero_reg  (b_zero)
  );

  // ------------------------------------------------------------
  // capture pin sync and 1 Hz divider
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cap_sync_reg <= 3'b000;
      div_reg      <= 16'h0000;
    end else begin
      cap_sync_reg <= {cap_sync_reg[1:0], capture_pin_0};
      if (!(is_rtc && a_en)) begin
        div_reg <= 16'h0000;
      end else if (cap_sync_reg[1] && !cap_sync_reg[2]) begin
        div_reg <= (div_reg == 16'(RTC_DIVIDE - 1)) ? 16'h0000 : div_reg + 16'h0001;
      end
    end
  end

  assign rtc_tick  = is_rtc && a_en && cap_sync_reg[1] && !cap_sync_reg[2] &&
                     (div_reg == 16'(RTC_DIVIDE - 1)) &&
                     (timer_control_reg[CTL_CLOCK_STALL_OVERRIDE_ENABLE] || !(a_stalled || b_stalled));
  assign rtc_match = rtc_tick && (wide_count_reg == {second_half_match_reg, first_half_match_reg});

  // ------------------------------------------------------------
  // 32-bit counter
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wide_count_reg  <= {HALF_RST, HALF_RST};
      rtc_started_reg <= 1'b0;
    end else begin
      if (is_rtc && !rtc_started_reg) begin
        wide_count_reg  <= RTC_FIRST;
        rtc_started_reg <= 1'b1;
      end else if (is_rtc && rtc_tick) begin
        wide_count_reg <= rtc_match ? RTC_WRAP : wide_count_reg + 32'h1;
      end else if (is_tmr32 && load_a_wr) begin
        wide_count_reg <= {wdat[31:16], wdat[15:0]};
      end else if (tmr32_zero) begin
        wide_count_reg <= {second_half_load_reg, first_half_load_reg};
      end else if (tmr32_run) begin
        wide_count_reg <= wide_count_reg - 32'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt status and triggers; set wins over clear
  // ------------------------------------------------------------
  logic [INT_W-1:0] set_bits;
  always_comb begin
    set_bits          = '0;
    set_bits[INT_ATO] = tmr32_zero || (!is32 && a_zero);
    set_bits[INT_BTO] = !is32 && b_zero;
    set_bits[INT_RTC] = rtc_match;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      raw_int_status_reg <= '0;
      first_trigger_reg  <= 1'b0;
      second_trigger_reg <= 1'b0;
    end else begin
      raw_int_status_reg <= (raw_int_status_reg & ~(icr_wr ? wdat[INT_W-1:0] : '0)) | set_bits;
      first_trigger_reg  <= set_bits[INT_ATO] && timer_control_reg[CTL_AOTE];
      second_trigger_reg <= set_bits[INT_BTO] && timer_control_reg[CTL_BOTE];
    end
  end

  // ------------------------------------------------------------
  // read mux and ack
  // ------------------------------------------------------------
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    case (wb_adr_i)
      CFG_OFS:    rdata[2:0] = timer_config_reg;
      AMODE_OFS:  rdata[1:0] = first_half_mode_reg;
      BMODE_OFS:  rdata[1:0] = second_half_mode_reg;
      CTL_OFS:    rdata[CTL_W-1:0] = timer_control_reg;
      IMR_OFS:    rdata[INT_W-1:0] = int_mask_reg;
      RIS_OFS:    rdata[INT_W-1:0] = raw_int_status_reg;
      MIS_OFS:    rdata[INT_W-1:0] = raw_int_status_reg & int_mask_reg;
      ALOAD_OFS:  rdata = is32 ? {second_half_load_reg, first_half_load_reg} : {16'h0, first_half_load_reg};
      BLOAD_OFS:  rdata[15:0] = second_half_load_reg;
      AMATCH_OFS: rdata = is32 ? {second_half_match_reg, first_half_match_reg} : {16'h0, first_half_match_reg};
      BMATCH_OFS: rdata[15:0] = second_half_match_reg;
      APRE_OFS:   rdata[7:0] = first_half_prescale_reg;
      BPRE_OFS:   rdata[7:0] = second_half_prescale_reg;
      ACOUNT_OFS: rdata = is32 ? wide_count_reg : {16'h0, a_count};
      BCOUNT_OFS: rdata[15:0] = is32 ? wide_count_reg[31:16] : b_count;
      default:    rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= (bus_req && !wb_we_i) ? rdata : 32'h0000_0000;
    end
  end

endmodule

// >>> testbench/gp_timer_checker.sv
// checker for the general timer: bus handshake, read data, triggers.
// assumes it is bound to gp_timer and sees only its ports.
`timescale 1ns/1ns
module gp_timer_checker
  import gp_timer_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        first_trigger_reg,
  input wire logic        second_trigger_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------
  // shadow of written control values
  // ----------------------------------------
  // a write lands on the edge that raises ack, the shadows one edge later while ack is high
  logic       wr_hit;
  logic [2:0] cfg_reg;
  logic       aote_reg;
  logic       bote_reg;
  logic       bload_wr_reg;
  assign wr_hit = wb_ack_o && wb_we_i && wb_cyc_i && wb_stb_i;
  always_ff @(posedge clk) begin
    if (!nrst) cfg_reg <= 3'h0;
    else if (wr_hit && wb_adr_i == CFG_OFS) cfg_reg <= wb_dat_i[2:0];
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      aote_reg <= 1'b0;
      bote_reg <= 1'b0;
    end else if (wr_hit && wb_adr_i == CTL_OFS) begin
      aote_reg <= wb_dat_i[CTL_AOTE];
      bote_reg <= wb_dat_i[CTL_BOTE];
    end
  end
  // a joined load write also touches the second half, so either counts
  always_ff @(posedge clk) begin
    if (!nrst) bload_wr_reg <= 1'b0;
    else if (wr_hit && (wb_adr_i == BLOAD_OFS || wb_adr_i == ALOAD_OFS)) bload_wr_reg <= 1'b1;
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_latency_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack not given one cycle after request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  trig_pulse_a: assert property (first_trigger_reg |=> !first_trigger_reg)
    else $error("trigger longer than one cycle");
  trig_gate_a: assert property (first_trigger_reg |-> aote_reg)
    else $error("trigger without trigger enable");
  trig_b_gate_a: assert property (second_trigger_reg |-> bote_reg)
    else $error("second trigger without its enable");
  cfg_read_a: assert property ((wb_ack_o && !wb_we_i && wb_adr_i == CFG_OFS)
    |-> wb_dat_o == {29'h0, cfg_reg}) else $error("config read differs from written value");
  bload_rst_a: assert property ((wb_ack_o && !wb_we_i && wb_adr_i == BLOAD_OFS && !bload_wr_reg)
    |-> wb_dat_o[15:0] == HALF_RST) else $error("second load not at reset value");
endmodule

bind gp_timer gp_timer_checker chk (
  .clk                (clk),
  .nrst               (nrst),
  .wb_cyc_i           (wb_cyc_i),
  .wb_stb_i           (wb_stb_i),
  .wb_we_i            (wb_we_i),
  .wb_adr_i           (wb_adr_i),
  .wb_dat_i           (wb_dat_i),
  .wb_dat_o           (wb_dat_o),
  .wb_ack_o           (wb_ack_o),
  .first_trigger_reg  (first_trigger_reg),
  .second_trigger_reg (second_trigger_reg)
);

// >>> testbench/gp_timer_tb.sv
// testbench for the general timer: wishbone tasks, reset values, joined timer and clock mode.
// assumes the checker binds itself; the clock divide is shortened to 4 for run time.
`timescale 1ns/1ns
module gp_timer_tb
  import gp_timer_pkg::*;
;
  logic        clk, nrst, cyc, stb, we, ack, cap, stall, cap_run, trig_a;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat_w, dat_r, q, q2;
  int          err_count, comparisons, trig_n, t0, cap_div;

  gp_timer #(.RTC_DIVIDE(4)) uut (
    .clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .capture_pin_0(cap), .stall_in(stall), .first_trigger_reg(trig_a), .second_trigger_reg()
  );

  // ----------------------------------------
  // clock, reference clock, trigger count
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) if (trig_a === 1'b1) trig_n++;
  // reference runs far faster than real so a wrap fits in a short run
  always @(posedge clk) if (cap_run) begin
    cap_div <= (cap_div + 1) % 4;
    if (cap_div == 3) cap <= ~cap;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_w <= d; sel <= 4'hf;
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    q = dat_r;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 20) begin err_count++; $display("mismatch at %0t: no bus ack", $time); give_verdict; end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d); acc(1'b1, a, d); endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string m); acc(1'b0, a, 32'h0); chk(q, e, m); endtask
  task wait_ris(input int b, input int lim);
    int n;
    n = 0;
    do begin acc(1'b0, RIS_OFS, 32'h0); n++; end while (q[b] !== 1'b1 && n < lim);
    if (n >= lim) begin err_count++; $display("mismatch at %0t: status never set", $time); give_verdict; end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    nrst = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0; dat_w = 32'h0;
    cap = 1'b0; stall = 1'b0; cap_run = 1'b0; cap_div = 0; err_count = 0; comparisons = 0; trig_n = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rd(CFG_OFS, 32'h0, "cfg reset");
    rd(CTL_OFS, 32'h0, "ctl reset");
    rd(IMR_OFS, 32'h0, "mask reset");
    rd(RIS_OFS, 32'h0, "status reset");
    acc(1'b0, BLOAD_OFS, 32'h0); chk({16'h0, q[15:0]}, {16'h0, HALF_RST}, "second load reset");
    rd(APRE_OFS, {24'h0, PRE_RST}, "first prescale reset");
    rd(BPRE_OFS, {24'h0, PRE_RST}, "second prescale reset");
    rd(ACOUNT_OFS, {HALF_RST, HALF_RST}, "joined count reset");
    rd(8'h10, 32'h0, "unmapped read");
    $display("test reset done");
    wr(ALOAD_OFS, 32'h0003_0002);
    acc(1'b0, BLOAD_OFS, 32'h0); chk({16'h0, q[15:0]}, 32'h3, "upper load half");
    rd(ACOUNT_OFS, 32'h0003_0002, "joined count");
    $display("test split done");
    wr(ALOAD_OFS, 32'h14); wr(AMODE_OFS, {30'h0, MODE_ONESHOT}); wr(IMR_OFS, 32'h1 << INT_ATO);
    t0 = trig_n;
    wr(CTL_OFS, (32'h1 << CTL_AEN) | (32'h1 << CTL_AOTE));
    wait_ris(INT_ATO, 20);
    rd(CTL_OFS, 32'h1 << CTL_AOTE, "one-shot enable cleared");
    rd(ACOUNT_OFS, 32'h14, "one-shot reloaded and stopped");
    rd(MIS_OFS, 32'h1 << INT_ATO, "masked timeout");
    chk(32'(trig_n - t0), 32'h1, "trigger count");
    wr(ICR_OFS, 32'h1 << INT_ATO); rd(RIS_OFS, 32'h0, "timeout cleared");
    $display("test one-shot done");
    wr(BMODE_OFS, {30'h0, MODE_ONESHOT}); wr(AMODE_OFS, {30'h0, MODE_PERIOD}); wr(ALOAD_OFS, 32'h1000);
    stall <= 1'b1;
    wr(CTL_OFS, (32'h1 << CTL_AEN) | (32'h1 << CTL_ASTALL));
    acc(1'b0, ACOUNT_OFS, 32'h0); q2 = q; acc(1'b0, ACOUNT_OFS, 32'h0); chk(q, q2, "stalled count");
    stall <= 1'b0;
    acc(1'b0, ACOUNT_OFS, 32'h0); q2 = q; acc(1'b0, ACOUNT_OFS, 32'h0); chk(q, q2 - 3, "rate");
    wr(ALOAD_OFS, 32'h800);
    acc(1'b0, ACOUNT_OFS, 32'h0); chk({31'h0, q <= 32'h800 && q > 32'h7f8}, 32'h1, "reload running");
    t0 = trig_n;
    wr(ICR_OFS, 32'h1 << INT_ATO); wr(ALOAD_OFS, 32'h8);
    wait_ris(INT_ATO, 20);
    rd(CTL_OFS, (32'h1 << CTL_AEN) | (32'h1 << CTL_ASTALL), "periodic keeps enable");
    chk(32'(trig_n - t0), 32'h0, "trigger disabled");
    wr(CTL_OFS, 32'h0); wr(ICR_OFS, 32'h1 << INT_ATO); rd(RIS_OFS, 32'h0, "status cleared");
    $display("test periodic done");
    wr(CFG_OFS, {29'h0, CFG_16}); wr(AMODE_OFS, {30'h0, MODE_ONESHOT}); wr(ALOAD_OFS, 32'h0005_0007);
    rd(ACOUNT_OFS, 32'h7, "half count loaded");
    rd(BLOAD_OFS, 32'h0, "half load not split");
    wr(CTL_OFS, 32'h1 << CTL_AEN);
    wait_ris(INT_ATO, 20);
    rd(CTL_OFS, 32'h0, "half one-shot stops");
    wr(ICR_OFS, 32'h1 << INT_ATO); rd(RIS_OFS, 32'h0, "half status cleared");
    $display("test half done");
    wr(CFG_OFS, {29'h0, CFG_32_RTC});
    rd(ACOUNT_OFS, RTC_FIRST, "clock first value");
    wr(AMATCH_OFS, 32'h3); wr(IMR_OFS, 32'h1 << INT_RTC);
    stall <= 1'b1;
    cap_run <= 1'b1;
    wr(CTL_OFS, (32'h1 << CTL_AEN) | (32'h1 << CTL_ASTALL) | (32'h1 << CTL_CLOCK_STALL_OVERRIDE_ENABLE));
    wait_ris(INT_RTC, 60);
    rd(MIS_OFS, 32'h1 << INT_RTC, "clock masked flag");
    acc(1'b0, ACOUNT_OFS, 32'h0); chk({31'h0, q <= 32'h1}, 32'h1, "clock wrapped");
    wr(ICR_OFS, 32'h1 << INT_RTC);
    rd(RIS_OFS, 32'h0, "clock raw cleared");
    rd(MIS_OFS, 32'h0, "clock masked cleared");
    cap_run <= 1'b0;
    stall <= 1'b0;
    $display("test clock done");
    give_verdict;
  end
endmodule
